// ---- pkg/lpi_rx_pkg.sv ----
package lpi_rx_pkg;

   // ------------------------------------------------------------
   // clock
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;          // 40 MHz port clock

   // ------------------------------------------------------------
   // timer durations, in their own units
   // ------------------------------------------------------------
   localparam int QUIET_MIN_MS     = 2;         // quiet wait, 2..3 ms
   localparam int QUIET_MAX_MS     = 3;
   localparam int WAKE_LO_NS       = 10100;     // 10.1 us, no bypass
   localparam int WAKE_LO_BYP_NS   = 12300;     // 12.3 us, bypass
   localparam int WAKE_HI_BYP_NS   = 5700;      // 5.7 us, higher speed
   localparam int WAKE_FAULT_MS    = 10;        // at least 10 ms
   localparam int NS_PER_MS        = 1000000;

   // ------------------------------------------------------------
   // derived cycle counts (least times round up)
   // ------------------------------------------------------------
   localparam int QUIET_CYC =
      (QUIET_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_LO_CYC =
      (WAKE_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_LO_BYP_CYC =
      (WAKE_LO_BYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_HI_BYP_CYC =
      (WAKE_HI_BYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_FAULT_CYC =
      (WAKE_FAULT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int TMR_W = 20;                   // holds 400000

   // ------------------------------------------------------------
   // received symbol codes
   // ------------------------------------------------------------
   localparam int SYM_W = 2;
   localparam logic [SYM_W-1:0] SYM_OTHER = 2'h0;
   localparam logic [SYM_W-1:0] SYM_IDLE  = 2'h1;
   localparam logic [SYM_W-1:0] SYM_LPI   = 2'h2;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic RST_LOW_POWER  = 1'b0;
   localparam logic RST_MODE_QUIET = 1'b0;     // 0 = DATA, 1 = QUIET
   localparam logic RST_LINK_FAIL  = 1'b0;

   // ------------------------------------------------------------
   // receive machine states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_FULL_ACTIVE,
      ST_SLEEP,
      ST_QUIET,
      ST_WAKE,
      ST_WAKE_FAULT,
      ST_LINK_FAIL,
      ST_FAST_WAKE
   } rx_state_t;

endpackage : lpi_rx_pkg

// ---- pkg/lpi_timer_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// start strobe and terminal count in, expiry level out
interface lpi_timer_if #(
   parameter int W = 20
);
   logic         start;
   logic [W-1:0] load;
   logic         done;

   modport ctl (output start, output load, input done);
   modport tmr (input start, input load, output done);
endinterface : lpi_timer_if

`default_nettype wire

// ---- core/lpi_rx_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module lpi_rx_timer #(
   parameter int W = 20
) (
   // clock and reset
   input  wire logic   i_clk,
   input  wire logic   i_rst_n,
   input  wire logic   i_ce,
   // control
   lpi_timer_if.tmr    t
);

   logic [W-1:0] cnt_r;
   logic         armed_r;

   // ------------------------------------------------------------
   // down counter
   // ------------------------------------------------------------

   // load on start, then count to zero
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_r <= '0;
      end else if (i_ce) begin
         if (t.start) begin
            cnt_r <= t.load;
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
         end
      end
   end

   // armed once started, until reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         armed_r <= 1'b0;
      end else if (i_ce && t.start) begin
         armed_r <= 1'b1;
      end
   end

   // expiry stays high until the next start; kept free of the start
   // strobe so that no combinational path loops back through the fsm
   assign t.done = armed_r && (cnt_r == '0);

endmodule : lpi_rx_timer

`default_nettype wire

// ---- core/lpi_rx_fsm.sv ----
`timescale 1ns/1ps
`default_nettype none

module lpi_rx_fsm #(
   parameter int QUIET_CYCLES = lpi_rx_pkg::QUIET_CYC,
   parameter int FAULT_CYCLES = lpi_rx_pkg::WAKE_FAULT_CYC
) (
   // clock, reset, enable
   input  wire logic                          i_clk,
   input  wire logic                          i_rst_n,
   input  wire logic                          i_ce,
   // port state
   input  wire logic                          i_port_active,
   // receive path, same clock
   input  wire logic                          i_word_lock,
   input  wire logic [lpi_rx_pkg::SYM_W-1:0]  i_rx_symbol,
   // analog detector, asynchronous
   input  wire logic                          i_signal_present,
   // configuration
   input  wire logic                          i_quick_wake_enabled,
   input  wire logic                          i_scr_bypass_enable,
   input  wire logic                          i_high_speed,
   // status
   output logic                               o_low_power_flag,
   output logic                               o_rx_mode_quiet,
   output logic                               o_link_fail,
   output logic                               o_link_fail_pulse,
   output logic [2:0]                         o_state
);

   localparam int TW = lpi_rx_pkg::TMR_W;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   lpi_rx_pkg::rx_state_t state_r;
   lpi_rx_pkg::rx_state_t state_nxt;

   logic sp_meta_r;
   logic sp_sync_r;
   logic port_active_r;
   logic enter_active;
   logic is_lpi;
   logic is_idle;
   logic locked_lpi;
   logic locked_idle;
   logic entering;
   logic low_power_r;
   logic mode_quiet_r;
   logic link_fail_r;
   logic link_fail_pulse_r;
   logic [TW-1:0] wake_load;

   lpi_timer_if #(.W(TW)) quiet_t ();
   lpi_timer_if #(.W(TW)) wake_t ();
   lpi_timer_if #(.W(TW)) fault_t ();

   // ------------------------------------------------------------
   // symbol decode
   // ------------------------------------------------------------

   // compare a received code against one symbol
   function automatic logic sym_is(
      input logic [lpi_rx_pkg::SYM_W-1:0] code,
      input logic [lpi_rx_pkg::SYM_W-1:0] sym
   );
      sym_is = (code == sym);
   endfunction : sym_is

   // decoded symbol qualifiers
   assign is_lpi      = sym_is(i_rx_symbol, lpi_rx_pkg::SYM_LPI);
   assign is_idle     = sym_is(i_rx_symbol, lpi_rx_pkg::SYM_IDLE);
   assign locked_lpi  = i_word_lock && is_lpi;
   assign locked_idle = i_word_lock && is_idle;

   // ------------------------------------------------------------
   // input synchronisation
   // ------------------------------------------------------------

   // two-stage sync of the signal detector
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sp_meta_r <= 1'b0;
         sp_sync_r <= 1'b0;
      end else if (i_ce) begin
         sp_meta_r <= i_signal_present;
         sp_sync_r <= sp_meta_r;
      end
   end

   // remember port activity for entry detect
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         port_active_r <= 1'b0;
      end else if (i_ce) begin
         port_active_r <= i_port_active;
      end
   end

   assign enter_active = i_port_active && !port_active_r;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------

   // one transition evaluated per cycle
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         lpi_rx_pkg::ST_FULL_ACTIVE: begin
            if (locked_lpi) begin
               if (i_quick_wake_enabled) begin
                  state_nxt = lpi_rx_pkg::ST_FAST_WAKE;
               end else begin
                  state_nxt = lpi_rx_pkg::ST_SLEEP;
               end
            end
         end
         lpi_rx_pkg::ST_SLEEP: begin
            if (!i_word_lock) begin
               state_nxt = lpi_rx_pkg::ST_QUIET;
            end else if (is_idle) begin
               state_nxt = lpi_rx_pkg::ST_FULL_ACTIVE;
            end
         end
         lpi_rx_pkg::ST_QUIET: begin
            if (sp_sync_r) begin
               state_nxt = lpi_rx_pkg::ST_WAKE;
            end else if (quiet_t.done) begin
               state_nxt = lpi_rx_pkg::ST_LINK_FAIL;
            end
         end
         lpi_rx_pkg::ST_WAKE: begin
            if (wake_t.done) begin
               state_nxt = lpi_rx_pkg::ST_WAKE_FAULT;
            end else if (locked_idle) begin
               state_nxt = lpi_rx_pkg::ST_FULL_ACTIVE;
            end else if (locked_lpi) begin
               state_nxt = lpi_rx_pkg::ST_SLEEP;
            end
         end
         lpi_rx_pkg::ST_WAKE_FAULT: begin
            if (fault_t.done) begin
               state_nxt = lpi_rx_pkg::ST_LINK_FAIL;
            end else if (locked_lpi) begin
               state_nxt = lpi_rx_pkg::ST_SLEEP;
            end else if (i_word_lock) begin
               state_nxt = lpi_rx_pkg::ST_FULL_ACTIVE;
            end
         end
         lpi_rx_pkg::ST_LINK_FAIL: begin
            state_nxt = lpi_rx_pkg::ST_LINK_FAIL;
         end
         lpi_rx_pkg::ST_FAST_WAKE: begin
            if (!is_lpi) begin
               state_nxt = lpi_rx_pkg::ST_FULL_ACTIVE;
            end
         end
         default: begin
            state_nxt = lpi_rx_pkg::ST_FULL_ACTIVE;
         end
      endcase
      if (!i_port_active || enter_active) begin
         state_nxt = lpi_rx_pkg::ST_FULL_ACTIVE;
      end
   end

   assign entering = (state_nxt != state_r);

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_r <= lpi_rx_pkg::ST_FULL_ACTIVE;
      end else if (i_ce) begin
         state_r <= state_nxt;
      end
   end

   // ------------------------------------------------------------
   // timers
   // ------------------------------------------------------------

   // wake length by speed and bypass
   always_comb begin
      if (i_high_speed) begin
         wake_load = TW'(lpi_rx_pkg::WAKE_HI_BYP_CYC);
      end else if (i_scr_bypass_enable) begin
         wake_load = TW'(lpi_rx_pkg::WAKE_LO_BYP_CYC);
      end else begin
         wake_load = TW'(lpi_rx_pkg::WAKE_LO_CYC);
      end
   end

   assign quiet_t.start = entering && (state_nxt == lpi_rx_pkg::ST_SLEEP);
   assign quiet_t.load  = TW'(QUIET_CYCLES);

   assign wake_t.start  = entering && (state_nxt == lpi_rx_pkg::ST_WAKE);
   assign wake_t.load   = wake_load;

   assign fault_t.start = entering && (state_nxt == lpi_rx_pkg::ST_WAKE_FAULT);
   assign fault_t.load  = TW'(FAULT_CYCLES);

   lpi_rx_timer #(.W(TW)) u_quiet_tmr (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .t       (quiet_t)
   );

   lpi_rx_timer #(.W(TW)) u_wake_tmr (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .t       (wake_t)
   );

   lpi_rx_timer #(.W(TW)) u_fault_tmr (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .t       (fault_t)
   );

   // ------------------------------------------------------------
   // status outputs
   // ------------------------------------------------------------

   // low power flag
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         low_power_r <= lpi_rx_pkg::RST_LOW_POWER;
      end else if (i_ce) begin
         if (state_nxt == lpi_rx_pkg::ST_FULL_ACTIVE) begin
            low_power_r <= 1'b0;
         end else if (state_nxt == lpi_rx_pkg::ST_SLEEP) begin
            low_power_r <= 1'b1;
         end
      end
   end

   // receive mode, 1 = QUIET
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mode_quiet_r <= lpi_rx_pkg::RST_MODE_QUIET;
      end else if (i_ce) begin
         if (state_nxt == lpi_rx_pkg::ST_QUIET) begin
            mode_quiet_r <= 1'b1;
         end else if (state_nxt == lpi_rx_pkg::ST_WAKE
                      || state_nxt == lpi_rx_pkg::ST_FULL_ACTIVE) begin
            mode_quiet_r <= 1'b0;
         end
      end
   end

   // link failure level and entry pulse
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         link_fail_r       <= lpi_rx_pkg::RST_LINK_FAIL;
         link_fail_pulse_r <= 1'b0;
      end else if (i_ce) begin
         link_fail_r       <= (state_nxt == lpi_rx_pkg::ST_LINK_FAIL);
         link_fail_pulse_r <= entering
                              && (state_nxt == lpi_rx_pkg::ST_LINK_FAIL);
      end
   end

   // outputs from registers
   assign o_low_power_flag  = low_power_r;
   assign o_rx_mode_quiet   = mode_quiet_r;
   assign o_link_fail       = link_fail_r;
   assign o_link_fail_pulse = link_fail_pulse_r;
   assign o_state           = state_r;

endmodule : lpi_rx_fsm

`default_nettype wire

// ---- verif/lpi_rx_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpi_rx_monitor (
   // clock and inputs
   input wire logic       i_clk,
   input wire logic       i_rst_n,
   input wire logic       i_ce,
   input wire logic       i_port_active,
   input wire logic       i_word_lock,
   input wire logic [1:0] i_rx_symbol,
   input wire logic       i_quick_wake_enabled,
   // status
   input wire logic       o_low_power_flag,
   input wire logic       o_rx_mode_quiet,
   input wire logic       o_link_fail,
   input wire logic       o_link_fail_pulse,
   input wire logic [2:0] o_state
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // enabled edge, symbol decode
   wire go  = i_ce && i_port_active;
   wire lpi = i_rx_symbol == lpi_rx_pkg::SYM_LPI;
   wire idl = i_word_lock && i_rx_symbol == lpi_rx_pkg::SYM_IDLE;

   chk_hold_unlocked:
   assert property (go && o_state == 3'h0 && !i_word_lock |=> o_state == 3'h0)
      else $error("active left unlocked");
   chk_enter_sleep:
   assert property (go && o_state == 3'h0 && i_word_lock && lpi && !i_quick_wake_enabled
      |=> o_state == 3'h1) else $error("no sleep entry");
   chk_enter_fast:
   assert property (go && o_state == 3'h0 && i_word_lock && lpi && i_quick_wake_enabled
      |=> o_state == 3'h6) else $error("no fast entry");
   chk_sleep_idle:
   assert property (go && o_state == 3'h1 && idl |=> o_state == 3'h0)
      else $error("sleep kept on idle");
   chk_sleep_quiet:
   assert property (go && o_state == 3'h1 && !i_word_lock |=> o_state == 3'h2 && o_rx_mode_quiet)
      else $error("no quiet on lock loss");
   chk_fast_hold:
   assert property (go && o_state == 3'h6 |=> o_state == ($past(lpi) ? 3'h6 : 3'h0))
      else $error("fast wake path wrong");
   chk_full_clear:
   assert property (o_state == 3'h0 |-> !o_low_power_flag && !o_rx_mode_quiet)
      else $error("active flags set");
   chk_sleep_flag:
   assert property (o_state == 3'h1 |-> o_low_power_flag && !o_rx_mode_quiet)
      else $error("sleep flag clear");
   chk_fail_pulse:
   assert property ($rose(o_link_fail) |-> o_link_fail_pulse && o_state == 3'h5
      ##1 (!i_ce || !o_link_fail_pulse)) else $error("fail pulse wrong");
endmodule : lpi_rx_monitor

bind lpi_rx_fsm lpi_rx_monitor mon (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_port_active(i_port_active),
   .i_word_lock(i_word_lock), .i_rx_symbol(i_rx_symbol),
   .i_quick_wake_enabled(i_quick_wake_enabled), .o_low_power_flag(o_low_power_flag),
   .o_rx_mode_quiet(o_rx_mode_quiet), .o_link_fail(o_link_fail),
   .o_link_fail_pulse(o_link_fail_pulse), .o_state(o_state)
);
`default_nettype wire

// ---- verif/lpi_remote_tx.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpi_remote_tx (
   // commands
   input  wire logic       i_clk,
   input  wire logic       i_on,
   input  wire logic       i_lock,
   input  wire logic [1:0] i_sym,
   // link
   output logic            o_word_lock,
   output logic [1:0]      o_rx_symbol,
   output logic            o_signal_present
);
   logic [1:0] junk_r = 2'h0;
   logic       lock_r = 1'b0;
   logic [1:0] sym_r  = 2'h0;
   // filler that changes every cycle while off
   always_ff @(negedge i_clk) junk_r <= junk_r + 2'h1;
   // last lock and word, held one cycle after switch-off: lock trails the carrier
   always_ff @(negedge i_clk) begin
      lock_r <= i_on && i_lock;
      sym_r  <= i_on ? i_sym : junk_r;
   end
   assign o_rx_symbol      = i_on ? i_sym : sym_r;
   assign o_word_lock      = i_on ? i_lock : lock_r;
   assign o_signal_present = i_on;
endmodule : lpi_remote_tx
`default_nettype wire

// ---- verif/low_power_idle_receive_fsm_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module low_power_idle_receive_fsm_tb;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int QC = 20;
   localparam int FC = 40;
   localparam logic [1:0] L = lpi_rx_pkg::SYM_LPI;
   localparam logic [1:0] I = lpi_rx_pkg::SYM_IDLE;
   localparam logic [1:0] O = lpi_rx_pkg::SYM_OTHER;
   logic       i_clk = 1'b0;
   logic       i_rst_n = 1'b0;
   logic       i_ce = 1'b1;
   logic       i_port_active = 1'b1;
   logic       i_quick_wake_enabled = 1'b0;
   logic       i_scr_bypass_enable = 1'b0;
   logic       i_high_speed = 1'b0;
   logic       on = 1'b1;
   logic       lk = 1'b1;
   logic [1:0] sy = 2'h1;
   wire        i_word_lock, i_signal_present, o_low_power_flag, o_rx_mode_quiet;
   wire        o_link_fail, o_link_fail_pulse;
   wire  [1:0] i_rx_symbol;
   wire  [2:0] o_state;
   int         n_fail = 0, compares = 0, seed = 32'h3358_5837;
   int         st, fl, q, p, s1, s2, qc, wc, fc, ns;
   bit         qa, wa, fa, pa;

   always #12.5 i_clk = ~i_clk;

   lpi_rx_fsm #(.QUIET_CYCLES(QC), .FAULT_CYCLES(FC)) DUT (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_port_active(i_port_active),
      .i_word_lock(i_word_lock), .i_rx_symbol(i_rx_symbol),
      .i_signal_present(i_signal_present), .i_quick_wake_enabled(i_quick_wake_enabled),
      .i_scr_bypass_enable(i_scr_bypass_enable), .i_high_speed(i_high_speed),
      .o_low_power_flag(o_low_power_flag), .o_rx_mode_quiet(o_rx_mode_quiet),
      .o_link_fail(o_link_fail), .o_link_fail_pulse(o_link_fail_pulse), .o_state(o_state));
   lpi_remote_tx far (.i_clk(i_clk), .i_on(on), .i_lock(lk), .i_sym(sy),
      .o_word_lock(i_word_lock), .o_rx_symbol(i_rx_symbol),
      .o_signal_present(i_signal_present));

   // ------------------------------------------------------------
   // reference model, one step per enabled edge
   // ------------------------------------------------------------
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         {st, fl, q, p, s1, s2, qa, wa, fa, pa} = '0;
      end else if (i_ce) begin
         ns = st;
         case (st)
            0: if (i_word_lock && i_rx_symbol == L) ns = i_quick_wake_enabled ? 6 : 1;
            1: if (!i_word_lock) ns = 2; else if (i_rx_symbol == I) ns = 0;
            2: if (s2) ns = 3; else if (qa && qc == 0) ns = 5;
            3: if (wa && wc == 0) ns = 4; else if (i_word_lock && i_rx_symbol == I) ns = 0;
               else if (i_word_lock && i_rx_symbol == L) ns = 1;
            4: if (fa && fc == 0) ns = 5; else if (i_word_lock) ns = i_rx_symbol == L ? 1 : 0;
            6: ns = i_rx_symbol == L ? 6 : 0;
            default: ;
         endcase
         // port low or just entering active restarts in full-active
         if (!i_port_active || !pa) ns = 0;
         qc = qc > 0 ? qc - 1 : 0;
         wc = wc > 0 ? wc - 1 : 0;
         fc = fc > 0 ? fc - 1 : 0;
         if (ns == 1 && st != 1) {qa, qc, fl} = {1'b1, QC, 32'd1};
         if (ns == 3 && st != 3) {wa, wc} = {1'b1, i_high_speed ? lpi_rx_pkg::WAKE_HI_BYP_CYC :
            i_scr_bypass_enable ? lpi_rx_pkg::WAKE_LO_BYP_CYC : lpi_rx_pkg::WAKE_LO_CYC};
         if (ns == 4 && st != 4) {fa, fc} = {1'b1, FC};
         if (ns == 0) fl = 0;
         q = ns == 2 ? 1 : (ns == 0 || ns == 3) ? 0 : q;
         p = ns == 5 && st != 5;
         s2 = s1;
         s1 = i_signal_present;
         st = ns;
         pa = i_port_active;
      end
   end

   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp

   // every result against the model
   always @(negedge i_clk) cmp({1'b0, o_state, o_low_power_flag, o_rx_mode_quiet, o_link_fail,
      o_link_fail_pulse}, {1'b0, st[2:0], fl[0], q[0], st == 5, p[0]});

   task automatic close_out;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   task automatic drv(input logic o, input logic l, input logic [1:0] s, input int n);
      @(negedge i_clk);
      {on, lk, sy} <= {o, l, s};
      repeat (n - 1) @(negedge i_clk);
   endtask : drv

   task automatic wait_st(input logic [2:0] e, input int lim);
      int k;
      k = 0;
      while (o_state !== e && k < lim) begin
         @(negedge i_clk);
         k++;
      end
      cmp({5'h0, o_state}, {5'h0, e});
      if (o_state !== e) close_out();
   endtask : wait_st

   task automatic restart;
      i_port_active <= 1'b0;
      wait_st(3'h0, 3);
      i_port_active <= 1'b1;
   endtask : restart

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(negedge i_clk);
      i_rst_n <= 1'b1;
      drv(1, 1, L, 3);
      wait_st(3'h1, 2);
      drv(1, 1, I, 1);
      wait_st(3'h0, 3);
      drv(1, 1, L, 2);
      drv(0, 0, O, 3);
      wait_st(3'h2, 2);
      drv(1, 0, O, 1);
      wait_st(3'h3, 6);
      drv(1, 1, I, 1);
      wait_st(3'h0, 3);
      drv(1, 1, L, 2);
      drv(0, 0, O, 1);
      wait_st(3'h5, QC + 8);
      restart();
      for (int k = 0; k < 3; k++) begin
         i_high_speed <= k == 2;
         i_scr_bypass_enable <= k == 1;
         drv(1, 1, L, 2);
         drv(0, 0, O, 3);
         drv(1, 0, O, 1);
         wait_st(3'h3, 6);
         wait_st(3'h4, 520);
         if (k == 0) drv(1, 1, L, 1);
         if (k == 1) drv(1, 1, O, 1);
         if (k == 0) wait_st(3'h1, 3);
         if (k == 1) wait_st(3'h0, 3);
         if (k == 2) wait_st(3'h5, FC + 4);
         if (k == 2) restart();
      end
      drv(1, 1, L, 2);
      drv(0, 0, O, 3);
      drv(1, 0, O, 3);
      wait_st(3'h3, 3);
      drv(1, 1, L, 1);
      wait_st(3'h1, 3);
      i_quick_wake_enabled <= 1'b1;
      drv(1, 1, I, 2);
      drv(1, 1, L, 2);
      drv(1, 0, L, 3);
      wait_st(3'h6, 1);
      drv(1, 1, O, 1);
      wait_st(3'h0, 3);
      for (int k = 0; k < 4000; k++) begin
         @(negedge i_clk);
         on <= $random(seed) % 8 != 0;
         lk <= k % 300 > 1 && $random(seed) % 4 != 0;
         sy <= 2'($random(seed));
         i_ce <= k % 300 < 2 || $random(seed) % 8 != 0;
         i_port_active <= k % 300 != 0;
         if (k % 512 == 0) {i_quick_wake_enabled, i_high_speed, i_scr_bypass_enable} <=
            3'($random(seed));
      end
      close_out();
   end
endmodule : low_power_idle_receive_fsm_tb
`default_nettype wire
